// ---- shared/vpa_consts.svh ----
// Purpose: addresses, field positions, reset values of the palette access port
// Assumes: 16-bit legacy i/o addresses
// Notes: definitions only
`ifndef VPA_CONSTS_SVH
`define VPA_CONSTS_SVH

`define VPA_IO_ATTR_WR 16'h03c0
`define VPA_IO_ATTR_RD 16'h03c1
`define VPA_IO_PIX_MASK 16'h03c6
`define VPA_IO_RX_STATE 16'h03c7
`define VPA_IO_WX 16'h03c8
`define VPA_IO_DATA 16'h03c9
`define VPA_IO_STAT_MONO 16'h03ba
`define VPA_IO_STAT_COLOR 16'h03da

`define VPA_AIDX_COL_SEL 5'h14
`define VPA_AIDX_MODE_CTL 5'h10
`define VPA_AIDX_LAST_ENT 5'h0f

`define VPA_MODE_P54_SEL 7
`define VPA_MODE_RSVD 4
`define VPA_ARX_VIDEO_EN 5

`define VPA_RST_PIX_MASK 8'hff
`define VPA_RST_INDEX 8'h00
`define VPA_STATE_WX 2'h0
`define VPA_STATE_RX 2'h3

`define VPA_PAL_ENTRIES 256

`endif

// ---- shared/vpa_pkg.sv ----
// Purpose: types shared by the palette access port files
// Assumes: one palette entry is three bytes, red in the top byte
// Notes: none
package vpa_pkg;

    typedef logic [23:0] vpa_rgb_t;
    typedef logic [15:0][5:0] vpa_attr_ent_t;

    typedef enum logic [1:0] {VPA_RED, VPA_GREEN, VPA_BLUE} vpa_phase_e;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } vpa_io_req_s;

    typedef struct packed {
        logic [4:0] attr_idx;
        logic video_en;
        logic attr_flip;
        vpa_attr_ent_t attr_ent;
        logic [7:0] mode_ctl;
        logic [3:0] col_sel;
        logic [7:0] pix_mask;
        logic [7:0] rd_idx;
        logic [7:0] wr_idx;
        logic last_rx;
        vpa_phase_e phase;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] rdata;
        logic [7:0] disp_index;
        vpa_rgb_t disp_rgb;
    } vpa_state_s;

endpackage : vpa_pkg

// ---- verilog/vpa_index_merge.sv ----
// Purpose: forms the 8-bit palette index of a display pixel
// Assumes: attribute pixel is the 4-bit plane colour, pix_data the 8-bit frame pixel
// Notes: purely combinational
`timescale 1ns/1ps
`include "vpa_consts.svh"

module vpa_index_merge
    import vpa_pkg::*;
(
    input wire logic [3:0] attr_pixel,
    input wire vpa_attr_ent_t attr_ent,
    input wire logic p54_sel,
    input wire logic [3:0] col_sel,
    input wire logic [7:0] pix_data,
    input wire logic pix_indexed,
    input wire logic [7:0] pix_mask,
    output logic [7:0] index
);
    logic [5:0] ent;
    logic [1:0] p54;
    logic [7:0] raw;

    always_comb
    begin
        ent = attr_ent[attr_pixel];
        p54 = p54_sel ? col_sel[1:0] : ent[5:4];
        raw = pix_indexed ? pix_data : {col_sel[3:2], p54, ent[3:0]};
        index = raw & pix_mask;
    end

endmodule : vpa_index_merge

// ---- verilog/vpa_palette_store.sv ----
// Purpose: palette storage, one bank of entries per display pipe
// Assumes: whole-entry writes only
// Notes: reads are combinational
`timescale 1ns/1ps
`include "vpa_consts.svh"

module vpa_palette_store
    import vpa_pkg::*;
#(
    parameter int NUM_PIPES = 2,
    parameter int ENTRIES = `VPA_PAL_ENTRIES,
    localparam int PW = (NUM_PIPES > 1) ? $clog2(NUM_PIPES) : 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [PW-1:0] wr_pipe,
    input wire logic [7:0] wr_idx,
    input wire vpa_rgb_t wr_rgb,
    input wire logic [PW-1:0] hr_pipe,
    input wire logic [7:0] hr_idx,
    output vpa_rgb_t hr_rgb,
    input wire logic [PW-1:0] dr_pipe,
    input wire logic [7:0] dr_idx,
    output vpa_rgb_t dr_rgb
);
    vpa_rgb_t [NUM_PIPES-1:0][ENTRIES-1:0] mem;
    vpa_rgb_t [NUM_PIPES-1:0][ENTRIES-1:0] next_mem;

    always_comb
    begin
        next_mem = mem;
        if (wr_en)
        begin
            next_mem[wr_pipe][wr_idx] = wr_rgb;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem <= '0;
        end
        else
        begin
            mem <= next_mem;
        end
    end

    assign hr_rgb = mem[hr_pipe][hr_idx];
    assign dr_rgb = mem[dr_pipe][dr_idx];

endmodule : vpa_palette_store

// ---- verilog/vpa_top.sv ----
// Purpose: legacy palette access port with attribute index merge
// Assumes: i/o strobes are one-cycle pulses on clk, one access per cycle
// Notes: read data appears in io_rdata on the cycle after io_req.rd
`timescale 1ns/1ps
`include "vpa_consts.svh"

module vpa_top
    import vpa_pkg::*;
#(
    parameter int NUM_PIPES = 2,
    localparam int PW = (NUM_PIPES > 1) ? $clog2(NUM_PIPES) : 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire vpa_io_req_s io_req,
    output logic [7:0] io_rdata,
    input wire logic [PW-1:0] pipe_sel,
    input wire logic [3:0] attr_pixel,
    input wire logic [7:0] pix_data,
    input wire logic pix_indexed,
    input wire logic [PW-1:0] disp_pipe,
    output logic [7:0] disp_index,
    output vpa_rgb_t disp_rgb
);
    vpa_state_s st;
    vpa_state_s next_st;
    vpa_rgb_t host_rgb;
    vpa_rgb_t disp_lookup;
    logic [7:0] merged_index;
    logic store_wr;
    logic wr_port;
    logic rd_port;

    function automatic logic at(input logic [15:0] addr, input logic [15:0] port);
        at = (addr == port);
    endfunction : at

    function automatic logic [7:0] pick_byte(input vpa_rgb_t rgb, input vpa_phase_e ph);
        case (ph)
            VPA_RED: pick_byte = rgb[23:16];
            VPA_GREEN: pick_byte = rgb[15:8];
            VPA_BLUE: pick_byte = rgb[7:0];
            default: pick_byte = 8'h00;
        endcase
    endfunction : pick_byte

    assign wr_port = io_req.wr;
    assign rd_port = io_req.rd;
    // commit only on the third byte
    assign store_wr = wr_port && at(io_req.addr, `VPA_IO_DATA) && (st.phase == VPA_BLUE);

    vpa_palette_store #(
        .NUM_PIPES(NUM_PIPES),
        .ENTRIES(`VPA_PAL_ENTRIES)
    ) u_store (
        .clk(clk),
        .rst(rst),
        .wr_en(store_wr),
        .wr_pipe(pipe_sel),
        .wr_idx(st.wr_idx),
        .wr_rgb({st.red, st.green, io_req.wdata}),
        .hr_pipe(pipe_sel),
        .hr_idx(st.rd_idx),
        .hr_rgb(host_rgb),
        .dr_pipe(disp_pipe),
        .dr_idx(st.disp_index),
        .dr_rgb(disp_lookup)
    );

    vpa_index_merge u_merge (
        .attr_pixel(attr_pixel),
        .attr_ent(st.attr_ent),
        .p54_sel(st.mode_ctl[`VPA_MODE_P54_SEL]),
        .col_sel(st.col_sel),
        .pix_data(pix_data),
        .pix_indexed(pix_indexed),
        .pix_mask(st.pix_mask),
        .index(merged_index)
    );

    always_comb
    begin
        next_st = st;
        next_st.rdata = 8'h00;
        next_st.disp_index = merged_index;
        next_st.disp_rgb = disp_lookup;
        if (wr_port)
        begin
            if (at(io_req.addr, `VPA_IO_ATTR_WR))
            begin
                if (!st.attr_flip)
                begin
                    next_st.attr_idx = io_req.wdata[4:0];
                    next_st.video_en = io_req.wdata[`VPA_ARX_VIDEO_EN];
                end
                // data phase of the attribute port
                else if (st.attr_idx == `VPA_AIDX_COL_SEL)
                begin
                    next_st.col_sel = io_req.wdata[3:0];
                end
                else if (st.attr_idx == `VPA_AIDX_MODE_CTL)
                begin
                    next_st.mode_ctl = io_req.wdata;
                end
                else if (st.attr_idx <= `VPA_AIDX_LAST_ENT && !st.video_en)
                begin
                    next_st.attr_ent[st.attr_idx[3:0]] = io_req.wdata[5:0];
                end
                next_st.attr_flip = !st.attr_flip;
            end
            else if (at(io_req.addr, `VPA_IO_PIX_MASK))
            begin
                next_st.pix_mask = io_req.wdata;
            end
            else if (at(io_req.addr, `VPA_IO_RX_STATE))
            begin
                // load read index, drop partial write
                next_st.rd_idx = io_req.wdata;
                next_st.last_rx = 1'b1;
                next_st.phase = VPA_RED;
            end
            else if (at(io_req.addr, `VPA_IO_WX))
            begin
                // load write index, restart at red
                next_st.wr_idx = io_req.wdata;
                next_st.last_rx = 1'b0;
                next_st.phase = VPA_RED;
            end
            else if (at(io_req.addr, `VPA_IO_DATA))
            begin
                case (st.phase)
                    VPA_RED:
                    begin
                        next_st.red = io_req.wdata;
                        next_st.phase = VPA_GREEN;
                    end
                    VPA_GREEN:
                    begin
                        next_st.green = io_req.wdata;
                        next_st.phase = VPA_BLUE;
                    end
                    default:
                    begin
                        // next entry after the third byte
                        next_st.wr_idx = 8'(st.wr_idx + 8'h01);
                        next_st.phase = VPA_RED;
                    end
                endcase
            end
        end
        if (rd_port)
        begin
            if (at(io_req.addr, `VPA_IO_ATTR_WR))
            begin
                next_st.rdata = {2'h0, st.video_en, st.attr_idx};
            end
            else if (at(io_req.addr, `VPA_IO_ATTR_RD))
            begin
                if (st.attr_idx == `VPA_AIDX_COL_SEL)
                begin
                    next_st.rdata = {4'h0, st.col_sel};
                end
                else if (st.attr_idx == `VPA_AIDX_MODE_CTL)
                begin
                    next_st.rdata = st.mode_ctl;
                    next_st.rdata[`VPA_MODE_RSVD] = 1'b0;
                end
                else if (st.attr_idx <= `VPA_AIDX_LAST_ENT && !st.video_en)
                begin
                    next_st.rdata = {2'h0, st.attr_ent[st.attr_idx[3:0]]};
                end
            end
            else if (at(io_req.addr, `VPA_IO_STAT_MONO) || at(io_req.addr, `VPA_IO_STAT_COLOR))
            begin
                next_st.attr_flip = 1'b0;
            end
            else if (at(io_req.addr, `VPA_IO_PIX_MASK))
            begin
                next_st.rdata = st.pix_mask;
            end
            else if (at(io_req.addr, `VPA_IO_RX_STATE))
            begin
                next_st.rdata = {6'h00, st.last_rx ? `VPA_STATE_RX : `VPA_STATE_WX};
            end
            else if (at(io_req.addr, `VPA_IO_DATA))
            begin
                next_st.rdata = pick_byte(host_rgb, st.phase);
                case (st.phase)
                    VPA_RED: next_st.phase = VPA_GREEN;
                    VPA_GREEN: next_st.phase = VPA_BLUE;
                    default:
                    begin
                        // next entry after the third read
                        next_st.rd_idx = 8'(st.rd_idx + 8'h01);
                        next_st.phase = VPA_RED;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.pix_mask <= `VPA_RST_PIX_MASK;
            st.rd_idx <= `VPA_RST_INDEX;
            st.wr_idx <= `VPA_RST_INDEX;
            st.phase <= VPA_RED;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign io_rdata = st.rdata;
    assign disp_index = st.disp_index;
    assign disp_rgb = st.disp_rgb;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_rx_write_restart:
        assert property (wr_port && at(io_req.addr, `VPA_IO_RX_STATE)
            |=> st.phase == VPA_RED && st.rd_idx == $past(io_req.wdata)
            && st.wr_idx == $past(st.wr_idx))
        else $error("read index write did not restart sequencer");

    a_wx_write_load:
        assert property (wr_port && at(io_req.addr, `VPA_IO_WX)
            |=> st.wr_idx == $past(io_req.wdata) && st.phase == VPA_RED)
        else $error("write index load wrong");

    a_wr_commit_step:
        assert property (store_wr |=> st.wr_idx == 8'($past(st.wr_idx) + 8'h01))
        else $error("write index not advanced after commit");

    a_commit_third:
        assert property (store_wr |-> $past(st.phase) != VPA_RED)
        else $error("commit without full byte sequence");

    a_rd_step:
        assert property (rd_port && at(io_req.addr, `VPA_IO_DATA) && st.phase == VPA_BLUE
            |=> st.rd_idx == 8'($past(st.rd_idx) + 8'h01) && st.phase == VPA_RED)
        else $error("read index not advanced after blue");

    a_rd_red_byte:
        assert property (rd_port && at(io_req.addr, `VPA_IO_DATA) && st.phase == VPA_RED
            |=> io_rdata == $past(host_rgb[23:16]) && st.phase == VPA_GREEN)
        else $error("first data read is not red");

    a_state_rx:
        assert property (wr_port && at(io_req.addr, `VPA_IO_RX_STATE) ##1
            rd_port && at(io_req.addr, `VPA_IO_RX_STATE) |=> io_rdata == 8'h03)
        else $error("index state wrong after read index write");

    a_mask_index:
        assert property (pix_indexed |=> disp_index == ($past(pix_data) & $past(st.pix_mask)))
        else $error("masked pixel index wrong");

    a_top_bits:
        assert property (!pix_indexed |=> disp_index[7:6] == ($past(st.col_sel[3:2])
            & $past(st.pix_mask[7:6])))
        else $error("index bits 7:6 not from colour select");

endmodule : vpa_top

// ---- verif/vpa_tb.sv ----
// Purpose: self-checking bench for the palette access port
// Assumes: one i/o access per cycle, inputs driven 1 ns after the rising edge
// Notes: ordinary palette cases are table rows; reset cases come before them, corner cases follow
`timescale 1ns/1ps
`include "vpa_consts.svh"

module tb
    import vpa_pkg::*;
;
    typedef struct packed {
        logic pipe;
        logic [7:0] idx;
        vpa_rgb_t rgb;
        logic [7:0] mask;
        logic [7:0] pix;
        logic [7:0] exp_idx;
    } vpa_row_s;

    localparam vpa_row_s ROWS [0:5] = '{
        '{1'b0, 8'h00, 24'h12_3456, 8'hff, 8'h00, 8'h00},
        '{1'b1, 8'h5a, 24'hab_cdef, 8'h7e, 8'hdb, 8'h5a},
        '{1'b0, 8'hff, 24'hff_00ff, 8'hff, 8'hff, 8'hff},
        '{1'b1, 8'h81, 24'h00_ff01, 8'h81, 8'hff, 8'h81},
        '{1'b0, 8'h3c, 24'h5a_a55a, 8'h3c, 8'hff, 8'h3c},
        '{1'b0, 8'h00, 24'h01_0203, 8'h00, 8'ha7, 8'h00}
    };

    logic clk = 1'b0;
    logic rst;
    vpa_io_req_s io_req;
    logic [7:0] io_rdata;
    logic [0:0] pipe_sel;
    logic [0:0] disp_pipe;
    logic [3:0] attr_pixel;
    logic [7:0] pix_data;
    logic pix_indexed;
    logic [7:0] disp_index;
    vpa_rgb_t disp_rgb;
    logic [7:0] q;
    int errors = 0;
    int n_checks = 0;

    vpa_top #(.NUM_PIPES(2)) u_vpa_top (
        .clk(clk),
        .rst(rst),
        .io_req(io_req),
        .io_rdata(io_rdata),
        .pipe_sel(pipe_sel),
        .attr_pixel(attr_pixel),
        .pix_data(pix_data),
        .pix_indexed(pix_indexed),
        .disp_pipe(disp_pipe),
        .disp_index(disp_index),
        .disp_rgb(disp_rgb)
    );

    always #5 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one assignment per call, so back-to-back calls never drive twice in a step
    task automatic io_acc(input logic w, input logic r, input logic [15:0] a,
                          input logic [7:0] d);
        io_req = '{addr: a, wr: w, rd: r, wdata: d};
        @(posedge clk);
        #1;
    endtask : io_acc

    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        io_acc(1'b1, 1'b0, a, d);
    endtask : io_wr

    task automatic io_rd(input logic [15:0] a, output logic [7:0] r);
        io_acc(1'b0, 1'b1, a, 8'h00);
        r = io_rdata;
    endtask : io_rd

    task automatic io_idle();
        io_acc(1'b0, 1'b0, 16'h0000, 8'h00);
    endtask : io_idle

    task automatic pal_wr(input logic [7:0] idx, input vpa_rgb_t rgb);
        io_wr(`VPA_IO_WX, idx);
        io_wr(`VPA_IO_DATA, rgb[23:16]);
        io_wr(`VPA_IO_DATA, rgb[15:8]);
        io_wr(`VPA_IO_DATA, rgb[7:0]);
    endtask : pal_wr

    task automatic pal_chk(input logic [7:0] idx, input vpa_rgb_t rgb);
        io_wr(`VPA_IO_RX_STATE, idx);
        io_rd(`VPA_IO_DATA, q);
        chk("red", 24'(rgb[23:16]), 24'(q));
        io_rd(`VPA_IO_DATA, q);
        chk("green", 24'(rgb[15:8]), 24'(q));
        io_rd(`VPA_IO_DATA, q);
        chk("blue", 24'(rgb[7:0]), 24'(q));
    endtask : pal_chk

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("MISMATCH watchdog expected done seen running");
        end_of_test();
    end

    initial
    begin
        io_req = '0;
        pipe_sel = 1'b0;
        disp_pipe = 1'b0;
        attr_pixel = 4'h0;
        pix_data = 8'h00;
        pix_indexed = 1'b0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk("rst_rdata", 24'h00_0000, 24'(io_rdata));
        chk("rst_disp", 24'h00_0000, 24'(disp_index) | disp_rgb);
        rst = 1'b0;
        io_rd(`VPA_IO_RX_STATE, q);
        chk("state_rst", 24'h00_0000, 24'(q));
        io_rd(`VPA_IO_WX, q);
        chk("wx_read", 24'h00_0000, 24'(q));
        io_rd(`VPA_IO_PIX_MASK, q);
        chk("mask_rst", 24'h00_00ff, 24'(q));
        io_rd(16'h03c5, q);
        chk("unmapped", 24'h00_0000, 24'(q));
        for (int i = 0; i < 3; i++)
        begin
            io_rd(`VPA_IO_DATA, q);
            chk("rx_rst", 24'h00_0000, 24'(q));
        end
        io_wr(`VPA_IO_DATA, 8'h21);
        io_wr(`VPA_IO_DATA, 8'h43);
        io_wr(`VPA_IO_DATA, 8'h65);
        pal_chk(8'h00, 24'h21_4365);
        foreach (ROWS[i])
        begin
            pipe_sel = ROWS[i].pipe;
            disp_pipe = ROWS[i].pipe;
            pix_indexed = 1'b1;
            pix_data = ROWS[i].pix;
            io_wr(`VPA_IO_PIX_MASK, ROWS[i].mask);
            pal_wr(ROWS[i].idx, ROWS[i].rgb);
            pal_chk(ROWS[i].idx, ROWS[i].rgb);
            repeat (3) io_idle();
            chk("disp_index", 24'(ROWS[i].exp_idx), 24'(disp_index));
            chk("disp_rgb", ROWS[i].rgb, disp_rgb);
        end
        pipe_sel = 1'b1;
        pal_chk(8'h00, 24'h00_0000);
        pipe_sel = 1'b0;
        pal_chk(8'h00, 24'h01_0203);
        disp_pipe = 1'b1;
        repeat (3) io_idle();
        chk("pipe_rgb", 24'h00_0000, disp_rgb);
        disp_pipe = 1'b0;
        // index wraps from ff to 00 during a burst
        io_wr(`VPA_IO_WX, 8'hff);
        for (int i = 0; i < 6; i++)
            io_wr(`VPA_IO_DATA, 8'(8'h10 + i));
        io_wr(`VPA_IO_RX_STATE, 8'hff);
        for (int i = 0; i < 6; i++)
        begin
            io_rd(`VPA_IO_DATA, q);
            chk("burst", 24'(8'h10 + i), 24'(q));
        end
        io_wr(`VPA_IO_WX, 8'h40);
        io_wr(`VPA_IO_RX_STATE, 8'hff);
        io_wr(`VPA_IO_DATA, 8'h77);
        io_wr(`VPA_IO_DATA, 8'h88);
        io_wr(`VPA_IO_DATA, 8'h99);
        io_rd(`VPA_IO_DATA, q);
        chk("split_rd", 24'h00_0010, 24'(q));
        pal_chk(8'h40, 24'h77_8899);
        pix_data = 8'h60;
        io_wr(`VPA_IO_PIX_MASK, 8'hff);
        io_wr(`VPA_IO_WX, 8'h60);
        io_wr(`VPA_IO_DATA, 8'haa);
        io_wr(`VPA_IO_DATA, 8'hbb);
        repeat (3) io_idle();
        chk("partial", 24'h00_0000, disp_rgb);
        // read index load mid-write: next data read must be red of entry 40h
        io_wr(`VPA_IO_RX_STATE, 8'h40);
        io_rd(`VPA_IO_RX_STATE, q);
        chk("state_rx", 24'h00_0003, 24'(q));
        io_rd(`VPA_IO_DATA, q);
        chk("abandon", 24'h00_0077, 24'(q));
        io_wr(`VPA_IO_WX, 8'h60);
        io_rd(`VPA_IO_RX_STATE, q);
        chk("state_wx", 24'h00_0000, 24'(q));
        io_wr(`VPA_IO_DATA, 8'hcc);
        io_wr(`VPA_IO_DATA, 8'hdd);
        io_wr(`VPA_IO_DATA, 8'hee);
        repeat (3) io_idle();
        chk("restart", 24'hcc_ddee, disp_rgb);
        // attribute path: entry 3 = 2ah, colour select = 09h
        io_rd(`VPA_IO_STAT_COLOR, q);
        io_wr(`VPA_IO_ATTR_WR, 8'h03);
        io_wr(`VPA_IO_ATTR_WR, 8'h2a);
        io_wr(`VPA_IO_ATTR_WR, 8'h14);
        io_wr(`VPA_IO_ATTR_WR, 8'h09);
        io_wr(`VPA_IO_ATTR_WR, 8'h14);
        io_rd(`VPA_IO_ATTR_RD, q);
        chk("colour_select", 24'h00_0009, 24'(q));
        pix_indexed = 1'b0;
        attr_pixel = 4'h3;
        repeat (3) io_idle();
        chk("attr_entry", 24'h00_00aa, 24'(disp_index));
        // the last 3C0h index write (14h) left the flip-flop in data phase; return to index phase
        io_rd(`VPA_IO_STAT_COLOR, q);
        io_wr(`VPA_IO_ATTR_WR, 8'h10);
        io_wr(`VPA_IO_ATTR_WR, 8'h80);
        repeat (3) io_idle();
        chk("attr_alt", 24'h00_009a, 24'(disp_index));
        io_wr(`VPA_IO_PIX_MASK, 8'h0f);
        repeat (3) io_idle();
        chk("attr_mask", 24'h00_000a, 24'(disp_index));
        end_of_test();
    end
endmodule : tb
